/* rtl/cmd_decoder.sv */
// single-byte command decoder with calibration, sleep, sync and reset
`timescale 1ns/1ps
`include "cmd_decoder_cfg.svh"
module cmd_decoder #(
  parameter int CAL_LEN = `CAL_CYCLES
) (
  // clock, reset, enable
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       ce_in,
  // command byte strobe from serial port
  input  wire logic                       cmd_valid_in,
  input  wire logic [7:0]                 cmd_byte_in,
  // configuration from register file
  input  wire cmd_decoder_pkg::rate_cfg_t rate_cfg_in,
  // modulator result and measured calibration values
  input  wire logic signed [23:0]         sample_in,
  input  wire logic [23:0]                cal_measure_in,
  // outputs
  output logic                            data_ready_n_out,
  output logic signed [23:0]              result_out,
  output cmd_decoder_pkg::coeff_t         coeff_out,
  output logic                            continuous_read_mode_out,
  output logic                            sleep_out,
  output logic                            cal_busy_out,
  output logic                            reg_reset_out
);
  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  typedef struct packed {
    cmd_decoder_pkg::mode_t     mode;
    cmd_decoder_pkg::cal_kind_t kind;
    logic [7:0]                 cal_cnt;
    logic [2:0]                 ready_cnt;
    cmd_decoder_pkg::coeff_t    coeff;
    logic signed [23:0]         result;
    logic                       ready_n;
    logic                       cont;
    logic                       reg_reset;
  } dec_state_t;

  dec_state_t cur, next_cur;
  logic mod_tick, samp_tick, data_tick, restart;

  //--------------------------------------------------------------------
  // rate generation
  //--------------------------------------------------------------------
  // sync and reset both realign the conversion phase
  assign restart = cmd_valid_in &&
                   (cmd_byte_in == `OP_READY_SYNC ||
                    cmd_byte_in == `OP_RESET);

  rate_timer #(.CNT_W(24)) timer (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .restart_in   (restart),
    .cfg_in       (rate_cfg_in),
    .mod_tick_out (mod_tick),
    .samp_tick_out(samp_tick),
    .data_tick_out(data_tick)
  );

  //--------------------------------------------------------------------
  // command decode and sequencing
  //--------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.reg_reset = 1'b0;
    // data-ready low pulse times out back to high
    if (!cur.ready_n) begin
      if (cur.ready_cnt == 3'(`READY_LOW_CYCLES - 1)) begin
        next_cur.ready_n = 1'b1;
      end else begin
        next_cur.ready_cnt = cur.ready_cnt + 3'h1;
      end
    end
    case (cur.mode)
      cmd_decoder_pkg::st_idle: begin
        // new conversion result on each data-rate strobe
        if (data_tick) begin
          next_cur.result = sample_in;
          next_cur.ready_n = 1'b0;
          next_cur.ready_cnt = 3'h0;
        end
      end
      cmd_decoder_pkg::st_cal: begin
        // results withheld until the coefficient is in place
        if (mod_tick) begin
          next_cur.cal_cnt = cur.cal_cnt + 8'h1;
          if (cur.cal_cnt == 8'(CAL_LEN - 1)) begin
            next_cur.mode = cmd_decoder_pkg::st_update;
          end
        end
      end
      cmd_decoder_pkg::st_update: begin
        if (cur.kind == cmd_decoder_pkg::cal_sys_offset) begin
          next_cur.coeff.offset_correction_value = cal_measure_in;
        end else begin
          next_cur.coeff.gain_correction_value = cal_measure_in;
        end
        next_cur.mode = cmd_decoder_pkg::st_idle;
        next_cur.ready_n = 1'b0;
        next_cur.ready_cnt = 3'h0;
      end
      cmd_decoder_pkg::st_sleep: begin
        next_cur.ready_n = 1'b1;
      end
      default: begin
        next_cur.mode = cmd_decoder_pkg::st_idle;
      end
    endcase
    // opcodes; in sleep only sleep_exit_command and reset are honoured
    if (cmd_valid_in) begin
      if (cmd_byte_in == `OP_RESET) begin
        next_cur.coeff.offset_correction_value = `OFFSET_RESET;
        next_cur.coeff.gain_correction_value = `GAIN_RESET;
        next_cur.cont = 1'b0;
        next_cur.mode = cmd_decoder_pkg::st_idle;
        next_cur.ready_n = 1'b1;
        next_cur.reg_reset = 1'b1;
      end else if (cur.mode == cmd_decoder_pkg::st_sleep) begin
        if (cmd_byte_in == `OP_SLEEP_EXIT) begin
          next_cur.mode = cmd_decoder_pkg::st_idle;
        end
      end else if (cmd_byte_in == `OP_SLEEP) begin
        next_cur.mode = cmd_decoder_pkg::st_sleep;
        next_cur.ready_n = 1'b1;
      end else if (cmd_byte_in == `OP_HALT_CONT) begin
        next_cur.cont = 1'b0;
      end else if (cmd_byte_in == `OP_CONT_READ) begin
        next_cur.cont = 1'b1;
      end else if (cmd_byte_in == `OP_READY_SYNC) begin
        next_cur.ready_n = 1'b1;
      end else if (cur.mode == cmd_decoder_pkg::st_idle &&
                   (cmd_byte_in == `OP_GAIN_SELF_CAL ||
                    cmd_byte_in == `OP_SYS_OFFSET_CAL ||
                    cmd_byte_in == `OP_SYS_GAIN_CAL)) begin
        next_cur.mode = cmd_decoder_pkg::st_cal;
        next_cur.cal_cnt = 8'h0;
        next_cur.ready_n = 1'b1;
        if (cmd_byte_in == `OP_SYS_OFFSET_CAL) begin
          next_cur.kind = cmd_decoder_pkg::cal_sys_offset;
        end else if (cmd_byte_in == `OP_SYS_GAIN_CAL) begin
          next_cur.kind = cmd_decoder_pkg::cal_sys_gain;
        end else begin
          next_cur.kind = cmd_decoder_pkg::cal_gain_self;
        end
      end
      // any other byte falls through unchanged
    end
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  // synchronous reset to power-up values
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cur <= '{mode: cmd_decoder_pkg::st_idle,
               kind: cmd_decoder_pkg::cal_gain_self,
               cal_cnt: 8'h0, ready_cnt: 3'h0,
               coeff: '{`OFFSET_RESET, `GAIN_RESET},
               result: 24'h000000, ready_n: 1'b1,
               cont: 1'b0, reg_reset: 1'b0};
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign data_ready_n_out = cur.ready_n;
  assign result_out = cur.result;
  assign coeff_out = cur.coeff;
  assign continuous_read_mode_out = cur.cont;
  assign sleep_out = (cur.mode == cmd_decoder_pkg::st_sleep);
  assign cal_busy_out = (cur.mode == cmd_decoder_pkg::st_cal) ||
                        (cur.mode == cmd_decoder_pkg::st_update);
  assign reg_reset_out = cur.reg_reset;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sleep_entry_a: assert property (ce_in && cmd_valid_in &&
    cmd_byte_in == `OP_SLEEP && !sleep_out |=> sleep_out)
    else $error("sleep opcode ignored");
  sleep_exit_a: assert property (ce_in && sleep_out &&
    !(cmd_valid_in && (cmd_byte_in == `OP_SLEEP_EXIT ||
      cmd_byte_in == `OP_RESET)) |=> sleep_out)
    else $error("sleep left without sleep_exit_command");
  wake_a: assert property (ce_in && sleep_out && cmd_valid_in &&
    cmd_byte_in == `OP_SLEEP_EXIT |=> !sleep_out)
    else $error("sleep_exit_command opcode ignored");
  reset_coeff_a: assert property (ce_in && cmd_valid_in &&
    cmd_byte_in == `OP_RESET |=> coeff_out.offset_correction_value ==
    `OFFSET_RESET && coeff_out.gain_correction_value == `GAIN_RESET)
    else $error("reset opcode left coefficients");
  reset_cont_a: assert property (ce_in && cmd_valid_in &&
    cmd_byte_in == `OP_RESET |=> !continuous_read_mode_out)
    else $error("reset left continuous read");
  cont_hold_a: assert property (ce_in && continuous_read_mode_out &&
    !(cmd_valid_in && (cmd_byte_in == `OP_HALT_CONT ||
      cmd_byte_in == `OP_RESET)) |=> continuous_read_mode_out)
    else $error("continuous read dropped");
  cal_quiet_a: assert property (cal_busy_out && $past(cal_busy_out)
    |-> data_ready_n_out) else $error("data ready during calibration");
  offset_load_a: assert property (ce_in &&
    cur.mode == cmd_decoder_pkg::st_update &&
    cur.kind == cmd_decoder_pkg::cal_sys_offset && !cmd_valid_in |=>
    coeff_out.offset_correction_value == $past(cal_measure_in) &&
    !data_ready_n_out) else $error("offset not loaded");
  gain_load_a: assert property (ce_in &&
    cur.mode == cmd_decoder_pkg::st_update &&
    cur.kind != cmd_decoder_pkg::cal_sys_offset && !cmd_valid_in |=>
    coeff_out.gain_correction_value == $past(cal_measure_in))
    else $error("gain not loaded");
  unknown_a: assert property (ce_in && cmd_valid_in &&
    cmd_byte_in == 8'hff && cur.mode == cmd_decoder_pkg::st_idle &&
    !data_tick |=> coeff_out == $past(coeff_out) &&
    continuous_read_mode_out == $past(continuous_read_mode_out))
    else $error("unknown opcode changed state");

  cal_seen_c: cover property (cal_busy_out ##1 !cal_busy_out);
  sleep_seen_c: cover property (sleep_out ##1 !sleep_out);
  ready_seen_c: cover property (!data_ready_n_out && continuous_read_mode_out);
endmodule

/* rtl/cmd_decoder_cfg.svh */
// timing counts, opcodes and reset values for the command decoder
`ifndef CMD_DECODER_CFG_SVH
`define CMD_DECODER_CFG_SVH
`define OP_GAIN_SELF_CAL   8'hf2
`define OP_SYS_OFFSET_CAL  8'hf3
`define OP_SYS_GAIN_CAL    8'hf4
`define OP_SLEEP_EXIT      8'hfb
`define OP_READY_SYNC      8'hfc
`define OP_SLEEP           8'hfd
`define OP_RESET           8'hfe
`define OP_CONT_READ       8'h03
`define OP_HALT_CONT       8'h0f
`define OFFSET_RESET       24'h000000
`define GAIN_RESET         24'h555559
`define MOD_DIV_SLOW       128
`define MOD_DIV_FAST_SHIFT 1
`define DATA_DIV           1280
`define CAL_CYCLES         16
`define READY_LOW_CYCLES   4
`endif

/* rtl/cmd_decoder_pkg.sv */
// types shared by the command decoder files
package cmd_decoder_pkg;
  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_cal    = 3'b001,
    st_update = 3'b011,
    st_sleep  = 3'b010
  } mode_t;

  typedef enum logic [1:0] {
    cal_gain_self  = 2'h0,
    cal_sys_offset = 2'h1,
    cal_sys_gain   = 2'h2
  } cal_kind_t;

  typedef struct packed {
    logic        speed;
    logic [1:0]  output_rate_select;
    logic [7:0]  gain;
  } rate_cfg_t;

  typedef struct packed {
    logic [23:0] offset_correction_value;
    logic [23:0] gain_correction_value;
  } coeff_t;
endpackage

/* rtl/rate_timer.sv */
// modulator, sample and output-rate strobes derived from the oscillator
`timescale 1ns/1ps
`include "cmd_decoder_cfg.svh"
module rate_timer #(
  parameter int CNT_W = 24
) (
  // clock, reset, enable
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      ce_in,
  // control
  input  wire logic                      restart_in,
  input  wire cmd_decoder_pkg::rate_cfg_t cfg_in,
  // strobes
  output logic                           mod_tick_out,
  output logic                           samp_tick_out,
  output logic                           data_tick_out
);
  typedef struct packed {
    logic [CNT_W-1:0] mod_cnt;
    logic [CNT_W-1:0] samp_cnt;
    logic [CNT_W-1:0] data_cnt;
    logic             mod_tick;
    logic             samp_tick;
    logic             data_tick;
  } timer_state_t;

  timer_state_t cur, next_cur;
  logic [CNT_W-1:0] mod_div, samp_div, data_div;

  // divider selection from speed, gain and rate field
  always_comb begin
    mod_div = CNT_W'(`MOD_DIV_SLOW) << cfg_in.speed;
    data_div = (mod_div * CNT_W'(`DATA_DIV)) << cfg_in.output_rate_select;
    if (cfg_in.gain >= 8'h40) begin
      samp_div = mod_div >> 3;
    end else if (cfg_in.gain == 8'h20) begin
      samp_div = mod_div >> 2;
    end else if (cfg_in.gain == 8'h10) begin
      samp_div = mod_div >> 1;
    end else begin
      samp_div = mod_div;
    end
  end

  // free counters; restart realigns all three phases
  always_comb begin
    next_cur = cur;
    next_cur.mod_tick = 1'b0;
    next_cur.samp_tick = 1'b0;
    next_cur.data_tick = 1'b0;
    if (restart_in) begin
      next_cur.mod_cnt = '0;
      next_cur.samp_cnt = '0;
      next_cur.data_cnt = '0;
    end else begin
      next_cur.mod_cnt = cur.mod_cnt + 1'b1;
      next_cur.samp_cnt = cur.samp_cnt + 1'b1;
      next_cur.data_cnt = cur.data_cnt + 1'b1;
      if (cur.mod_cnt >= mod_div - 1'b1) begin
        next_cur.mod_cnt = '0;
        next_cur.mod_tick = 1'b1;
      end
      if (cur.samp_cnt >= samp_div - 1'b1) begin
        next_cur.samp_cnt = '0;
        next_cur.samp_tick = 1'b1;
      end
      if (cur.data_cnt >= data_div - 1'b1) begin
        next_cur.data_cnt = '0;
        next_cur.data_tick = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cur <= '0;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign mod_tick_out = cur.mod_tick;
  assign samp_tick_out = cur.samp_tick;
  assign data_tick_out = cur.data_tick;

  // a data strobe implies a modulator strobe on the same cycle
  data_on_mod_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    data_tick_out |-> mod_tick_out) else $error("data tick off mod grid");
endmodule

/* verification/cmd_host_model.sv */
// host model that issues single command bytes to the decoder
`timescale 1ns/1ps
module cmd_host_model (
  // clock
  input  wire logic clk_in,
  // command port and conditioned calibration input
  output logic       cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic [23:0] cal_measure_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_byte_out = 8'h00;
    cal_measure_out = 24'h000000;
  end
  // input settles a cycle ahead of the opcode, byte lasts one cycle
  task automatic send_cmd(input logic [7:0] op, input logic [23:0] meas);
    @(negedge clk_in);
    cal_measure_out = meas;
    @(negedge clk_in);
    cmd_byte_out = op;
    cmd_valid_out = 1'b1;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_byte_out = ~op; // released byte never keeps its last value
  endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
`include "cmd_decoder_cfg.svh"
module tb;
  logic                       clk_in = 1'b0;
  logic                       rst_b_in;
  logic                       ce_in;
  cmd_decoder_pkg::rate_cfg_t rate_cfg;
  logic signed [23:0]         sample;
  logic                       cmd_valid;
  logic [7:0]                 cmd_byte;
  logic [23:0]                cal_measure;
  logic                       ready_n;
  logic signed [23:0]         result;
  cmd_decoder_pkg::coeff_t    coeff;
  logic                       cont;
  logic                       sleep;
  logic                       busy;
  logic                       reg_reset;
  int                         miscompares = 0;
  int                         num_checks = 0;
  logic [31:0]                seed = 32'h6340;
  logic [31:0]                r;
  logic [7:0]                 op;
  cmd_decoder_pkg::coeff_t    held;

  always #12.5 clk_in = ~clk_in;

  cmd_host_model host (.clk_in(clk_in), .cmd_valid_out(cmd_valid),
    .cmd_byte_out(cmd_byte), .cal_measure_out(cal_measure));

  cmd_decoder #(.CAL_LEN(2)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .ce_in(ce_in), .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte),
    .rate_cfg_in(rate_cfg), .sample_in(sample),
    .cal_measure_in(cal_measure), .data_ready_n_out(ready_n),
    .result_out(result), .coeff_out(coeff),
    .continuous_read_mode_out(cont), .sleep_out(sleep),
    .cal_busy_out(busy), .reg_reset_out(reg_reset));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic is_known(input logic [7:0] b);
    return b inside {8'hf2, 8'hf3, 8'hf4, 8'hfb, 8'hfc, 8'hfd, 8'hfe,
                     8'h03, 8'h0f};
  endfunction

  // calibration loads only the field that its kind corrects
  function automatic cmd_decoder_pkg::coeff_t exp_coeff(
    input logic [7:0] b, input logic [23:0] m,
    input cmd_decoder_pkg::coeff_t old);
    exp_coeff = old;
    if (b == 8'hf3) begin
      exp_coeff.offset_correction_value = m;
    end else begin
      exp_coeff.gain_correction_value = m;
    end
  endfunction

  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // new random config and sample off the sampling edge
  task automatic shake();
    r = xorshift();
    rate_cfg.speed = r[5];
    rate_cfg.output_rate_select = (r[4:3] == 2'h3) ? 2'h2 : r[4:3];
    rate_cfg.gain = 8'h01 << r[2:0];
    sample = r[31:8];
  endtask

  // a second cal opcode while busy must not touch the other field
  task automatic run_cal(input logic [7:0] b, input logic cut);
    logic [23:0] m;
    cmd_decoder_pkg::coeff_t e;
    int n;
    r = xorshift();
    m = r[23:0];
    e = exp_coeff(b, m, coeff);
    host.send_cmd(b, m);
    check("busy", 48'h1, 48'(busy));
    host.send_cmd((b == 8'hf3) ? 8'hf4 : 8'hf3, m);
    n = 0;
    while (busy !== 1'b0 && n < 1200) begin
      @(negedge clk_in);
      n++;
    end
    check("cal wait", 48'h0, 48'(n >= 1200));
    check("coeff", e, coeff);
    check("ready", 48'h0, 48'(ready_n));
    if (cut) begin
      host.send_cmd(8'hfc, m);
      check("sync ready", 48'h1, 48'(ready_n));
    end else begin
      repeat (3) begin
        @(negedge clk_in);
        check("ready low", 48'h0, 48'(ready_n));
      end
      @(negedge clk_in);
      check("ready high", 48'h1, 48'(ready_n));
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    rate_cfg = '{speed: 1'b0, output_rate_select: 2'h0, gain: 8'h01};
    sample = 24'sh000000;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    check("reset coeff", {24'h000000, `GAIN_RESET}, coeff);
    check("reset flags", 48'h8, 48'({ready_n, cont, sleep, busy}));
    // unknown bytes leave coeff bits 47:4 and the cont, sleep, busy and reg_reset outputs alone
    repeat (16) begin
      shake();
      r = xorshift();
      op = r[7:0];
      held = coeff;
      if (!is_known(op)) begin
        host.send_cmd(op, r[31:8]);
        check("unknown", {held[47:4], 4'h0},
              {coeff[47:4], cont, sleep, busy, reg_reset});
      end
    end
    // hand-picked corner: the all-ones byte decodes to nothing
    held = coeff;
    host.send_cmd(8'hff, 24'h123456);
    check("unknown ff", {held[47:4], 4'h0},
          {coeff[47:4], cont, sleep, busy, reg_reset});
    host.send_cmd(8'hfd, 24'h000000);
    check("sleep", 48'h1, 48'(sleep));
    host.send_cmd(8'hf2, 24'h000000);
    host.send_cmd(8'h03, 24'h000000);
    check("sleep refuse", 48'h1, 48'({busy, cont, sleep}));
    host.send_cmd(8'hfb, 24'h000000);
    check("wake", 48'h0, 48'(sleep));
    // a held clock enable freezes command intake
    ce_in = 1'b0;
    host.send_cmd(8'hfd, 24'h000000);
    ce_in = 1'b1;
    check("ce freeze", 48'h0, 48'(sleep));
    host.send_cmd(8'h03, 24'h000000);
    check("cont on", 48'h1, 48'(cont));
    shake();
    run_cal(8'hf2, 1'b0);
    shake();
    run_cal(8'hf3, 1'b0);
    shake();
    run_cal(8'hf4, 1'b1);
    check("cont kept", 48'h1, 48'(cont));
    host.send_cmd(8'h0f, 24'h000000);
    check("cont off", 48'h0, 48'(cont));
    host.send_cmd(8'h03, 24'h000000);
    host.send_cmd(8'hfe, 24'h000000);
    check("reg reset", 48'h1, 48'(reg_reset));
    check("reset cont", 48'h0, 48'(cont));
    check("reset coeff", {24'h000000, `GAIN_RESET}, coeff);
    @(negedge clk_in);
    check("reset pulse", 48'h0, 48'(reg_reset));
    // no data strobe fits in this run, so the result keeps its reset value
    check("result idle", 48'h0, 48'(result));
    final_report();
  end

  // cuts a hang short, well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    final_report();
  end
endmodule
